// ### verilog/scd_pkg.sv
/*
  Shared constants and carrier types of the serial register command decoder.
  Assumes one 200 MHz clock and a measurement converter outside this block.
*/
package scd_pkg;
  // --------------------------------------------------------------------
  // Command word and page layout
  // --------------------------------------------------------------------
  localparam int        CMD_W        = 16;
  localparam logic [3:0] PAGE_DATA   = 4'h0;
  localparam logic [3:0] PAGE_AUXCTL = 4'h1;
  localparam logic [3:0] PAGE_AUDIO  = 4'h2;
  localparam logic [6:0] PAGE_DEPTH  = 7'h20;
  localparam logic [15:0] ALL_ONES   = 16'hffff;
  localparam logic [15:0] ZERO_WORD  = 16'h0000;
  localparam logic [3:0] BIT_LAST    = 4'hf;

  // Result slots on the data page
  localparam logic [4:0] IDX_BATTERY_INPUT_ONE  = 5'h05;
  localparam logic [4:0] IDX_BATTERY_INPUT_TWO  = 5'h06;
  localparam logic [4:0] IDX_AUX   = 5'h07;
  localparam logic [4:0] IDX_TEMP_BASE_CURRENT_RESULT = 5'h09;
  localparam logic [4:0] IDX_TEMP_HIGH_CURRENT_RESULT = 5'h0a;

  // Measurement control and pin function select
  localparam logic [4:0] IDX_MEAS_CTRL = 5'h00;
  localparam int         MODE_LSB      = 0;
  localparam int         MODE_MSB      = 2;
  localparam logic [2:0] MODE_NONE     = 3'h0;
  localparam logic [2:0] MODE_SCAN     = 3'h1;
  localparam logic [2:0] MODE_TSINGLE  = 3'h2;
  localparam logic [2:0] MODE_TDIFF    = 3'h3;
  localparam logic [4:0] IDX_PIN_FUNC  = 5'h06;
  localparam int         PIN_FUNC_BIT  = 0;
  localparam int         RES_W         = 12;

  // --------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {CH_BATTERY_INPUT_ONE, CH_BATTERY_INPUT_TWO, CH_AUX, CH_TEMP} scd_chan_e;

  typedef struct packed {
    logic       rd;
    logic [3:0] page;
    logic [5:0] index;
    logic [4:0] spare;
  } scd_cmd_s;

  typedef struct packed {
    logic      start;
    scd_chan_e chan;
    logic      bias_high;
    logic      divider_en;
  } scd_conv_s;
endpackage : scd_pkg

// ### verilog/scd_decoder.sv
/*
  Serial register command decoder with measurement sequencer.
  Assumes an SPI master (idle-low clock, data driven on first edge) whose pins
  are asynchronous to ref_clk, and a converter that answers each start.
*/
// Overview of operation
// RULE_01 - Every access begins with a sixteen bit command word before any data.
// RULE_02 - Command bit fifteen high selects read; 0x8000 reads page zero from zero.
// RULE_03 - Command bits fourteen to eleven pick page zero, one or two; others reserved.
// RULE_04 - Command bits ten to five give the register index and start pointer.
// RULE_05 - Host sends the five lowest command bits as zero.
// RULE_06 - Reads return consecutive words, pointer advancing to the page end.
// RULE_07 - Reading past the last register of the page returns all ones.
// RULE_08 - Command 0x0800 writes page one starting at register zero.
// RULE_09 - Controller pulses hardware reset low then high after power up.
// RULE_10 - Hardware reset returns all registers, counters and states to initial values.
// RULE_11 - Dual-use pin defaults to active-low power-down input.
// RULE_12 - During power-down registers and sequencer counters hold their values.
// RULE_13 - A register bit switches the dual-use pin to converter word select.
// RULE_14 - One write starts port scan of both batteries and aux, updated together.
// RULE_15 - Battery divider is on only while a battery input is sampled.
// RULE_16 - Differential temperature converts at base then at 82 times current.
// RULE_17 - Single temperature mode takes one diode conversion at fixed current.
// RULE_18 - Clock idles low; both ends drive data from the first clock edge.
// RULE_19 - Command words are interpreted only after a slave select falling edge.
// RULE_20 - Results are right-justified twelve bit values with upper four bits zero.
// RULE_21 - Write data words store at the pointer then advance until select rises.
// RULE_22 - Reserved pages change nothing and read back as all ones.
`timescale 1ns/10ps
module scd_decoder
  import scd_pkg::*;
(
  // Clock and hardware reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // Serial pins
  input  wire logic                  sclk_pin,
  input  wire logic                  ss_n_pin,
  input  wire logic                  serial_data_in_pin,
  output logic                       serial_data_out_pin,
  output logic                       serial_data_out_oe,
  // Dual-use pin
  input  wire logic                  powerdown_or_wordselect_pin,
  output logic                       hw_powerdown_active,
  output logic                       converter_word_select,
  // Converter
  output scd_conv_s                  conv_req,
  input  wire logic                  conv_sample_end,
  input  wire logic                  conv_done,
  input  wire logic [RES_W-1:0]      conv_result
);
  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  logic       sclk_d_r;
  logic       ss_d_r;

  // Two flops per pin; only sync2_r is read by logic; reset to each pin's idle level
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      sync1_r <= 4'he;
      sync2_r <= 4'he;
    end
    else
    begin
      sync1_r <= {powerdown_or_wordselect_pin, serial_data_in_pin, ss_n_pin, sclk_pin};
      sync2_r <= sync1_r;
    end

  wire sclk_s = sync2_r[0];
  wire ss_s   = sync2_r[1];
  wire mosi_s = sync2_r[2];
  wire dual_s = sync2_r[3];

  // Edge history; reset to idle so no false edge after release
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      sclk_d_r <= 1'b0;
      ss_d_r   <= 1'b1;
    end
    else
    begin
      sclk_d_r <= sclk_s;
      ss_d_r   <= ss_s;
    end

  wire ss_fall   = ss_d_r & ~ss_s;                      // RULE_19
  wire active    = ~ss_s;
  wire sclk_rise = active & ~sclk_d_r & sclk_s;         // RULE_18
  wire sclk_fall = active & sclk_d_r & ~sclk_s;         // RULE_18

  // ----------------------------------------------------------------------
  // Serial framing and command decode
  // ----------------------------------------------------------------------
  logic [15:0] rx_sh_r;
  logic [3:0]  bit_cnt_r;
  logic        cmd_seen_r;
  scd_cmd_s    cmd_r;
  logic [6:0]  ptr_r;
  logic [15:0] tx_sh_r;
  logic        miso_r;
  logic [15:0] rd_word;
  logic        wr_stb;

  wire [15:0] rx_word   = {rx_sh_r[14:0], mosi_s};
  wire        word_done = sclk_fall & (bit_cnt_r == BIT_LAST);
  wire        cmd_done  = word_done & ~cmd_seen_r;
  wire        data_done = word_done & cmd_seen_r;
  scd_cmd_s   new_cmd;
  assign new_cmd = scd_cmd_s'(rx_word);
  wire        page_ok   = (cmd_r.page == PAGE_DATA) | (cmd_r.page == PAGE_AUXCTL) | (cmd_r.page == PAGE_AUDIO);
  wire [6:0]  ptr_inc   = (ptr_r < PAGE_DEPTH) ? ptr_r + 7'h01 : PAGE_DEPTH;

  // Bit shifting on the sampling (second) edge; frame restarts at select fall
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      rx_sh_r   <= ZERO_WORD;
      bit_cnt_r <= 4'h0;
    end
    else if (ss_fall || ss_s)
    begin
      bit_cnt_r <= 4'h0;
    end
    else if (sclk_fall)
    begin
      rx_sh_r   <= rx_word;
      bit_cnt_r <= bit_cnt_r + 4'h1;
    end

  // First word after select fall is the command; later words are data
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      cmd_seen_r <= 1'b0;
      cmd_r      <= '0;
      ptr_r      <= 7'h00;
    end
    else if (ss_fall || ss_s)
    begin
      cmd_seen_r <= 1'b0;                               // RULE_01
    end
    else if (cmd_done)
    begin
      cmd_seen_r <= 1'b1;                               // RULE_01
      cmd_r      <= new_cmd;                            // RULE_02 RULE_03 RULE_08
      ptr_r      <= {1'b0, new_cmd.index};              // RULE_04
    end
    else if (data_done)
    begin
      ptr_r      <= ptr_inc;                            // RULE_06 RULE_21
    end

  // Spare command bits are left to the host and not checked
  wire unused_spare = ^cmd_r.spare;                     // RULE_05

  // Word to send next: loaded after the command or after each data word
  wire [6:0] load_ptr = cmd_done ? {1'b0, new_cmd.index} : ptr_inc;
  wire [3:0] load_pg  = cmd_done ? new_cmd.page : cmd_r.page;
  wire       load_rd  = cmd_done ? new_cmd.rd : cmd_r.rd;

  // Transmit shifter; drives on the first (rising) edge of each bit
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      tx_sh_r <= ZERO_WORD;
      miso_r  <= 1'b0;
    end
    else if (ss_fall)
    begin
      tx_sh_r <= ZERO_WORD;
    end
    else if (word_done)
    begin
      tx_sh_r <= load_rd ? rd_word : ZERO_WORD;         // RULE_06
    end
    else if (sclk_rise)
    begin
      miso_r  <= tx_sh_r[15];                           // RULE_18
      tx_sh_r <= {tx_sh_r[14:0], 1'b0};
    end

  assign serial_data_out_pin = miso_r;
  assign serial_data_out_oe  = active;
  assign wr_stb = data_done & ~cmd_r.rd & page_ok & (ptr_r < PAGE_DEPTH)
                  & (cmd_r.page != PAGE_DATA);          // RULE_21 RULE_22

  // ----------------------------------------------------------------------
  // Register storage: control pages one and two
  // ----------------------------------------------------------------------
  logic [15:0] ctl_r [2][32];
  logic [15:0] res_r [5];

  genvar gp, gi;
  generate
    for (gp = 0; gp < 2; gp++)
    begin : g_page
      for (gi = 0; gi < 32; gi++)
      begin : g_reg
        // Each control word; only hardware reset clears it
        always_ff @(posedge ref_clk or negedge rst_n)
          if (!rst_n)
            ctl_r[gp][gi] <= ZERO_WORD;                 // RULE_10
          else if (wr_stb && cmd_r.page == 4'(gp + 1) && ptr_r[4:0] == 5'(gi))
            ctl_r[gp][gi] <= rx_word;                   // RULE_21
      end
    end
  endgenerate

  // Read mux: result page, control pages, all ones past end or reserved
  always_comb
  begin
    rd_word = ALL_ONES;
    if (load_ptr < PAGE_DEPTH)                          // RULE_07
    begin
      case (load_pg)
        PAGE_DATA:
        begin
          case (load_ptr[4:0])
            IDX_BATTERY_INPUT_ONE:  rd_word = res_r[0];
            IDX_BATTERY_INPUT_TWO:  rd_word = res_r[1];
            IDX_AUX:   rd_word = res_r[2];
            IDX_TEMP_BASE_CURRENT_RESULT: rd_word = res_r[3];
            IDX_TEMP_HIGH_CURRENT_RESULT: rd_word = res_r[4];
            default:   rd_word = ZERO_WORD;
          endcase
        end
        PAGE_AUXCTL: rd_word = ctl_r[0][load_ptr[4:0]];
        PAGE_AUDIO:  rd_word = ctl_r[1][load_ptr[4:0]];
        default:     rd_word = ALL_ONES;                // RULE_22
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Dual-use pin
  // ----------------------------------------------------------------------
  wire pin_is_ws = ctl_r[1][IDX_PIN_FUNC][PIN_FUNC_BIT]; // RULE_13
  wire pd        = ~pin_is_ws & ~dual_s;                 // RULE_11

  // Registered pin function outputs
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      hw_powerdown_active   <= 1'b0;
      converter_word_select <= 1'b0;
    end
    else
    begin
      hw_powerdown_active   <= pd;                      // RULE_11
      converter_word_select <= pin_is_ws & dual_s;      // RULE_13
    end

  // ----------------------------------------------------------------------
  // Measurement sequencer
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {SEQ_IDLE, SEQ_REQ, SEQ_WAIT, SEQ_COMMIT} scd_seq_e;
  scd_seq_e           seq_r;
  logic [2:0]         mode_r;
  logic [1:0]         step_r;
  logic [RES_W-1:0]   tmp_r [3];
  logic               sampled_r;
  scd_chan_e          chan;
  logic [1:0]         last_step;

  wire [2:0] wr_mode = rx_word[MODE_MSB:MODE_LSB];
  wire       trigger = wr_stb & (cmd_r.page == PAGE_AUXCTL) & (ptr_r[4:0] == IDX_MEAS_CTRL)
                       & (wr_mode != MODE_NONE);        // RULE_14

  // Channel order per mode
  always_comb
  begin
    chan      = CH_TEMP;
    last_step = 2'h0;
    case (mode_r)
      MODE_SCAN:
      begin
        chan      = scd_chan_e'(step_r);               // RULE_14
        last_step = 2'h2;
      end
      MODE_TDIFF: last_step = 2'h1;                    // RULE_16
      default:    last_step = 2'h0;                    // RULE_17
    endcase
  end

  // Sequencer state; frozen while powered down
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      seq_r  <= SEQ_IDLE;
      mode_r <= MODE_NONE;
      step_r <= 2'h0;
    end
    else if (!pd)                                      // RULE_12
    begin
      case (seq_r)
        SEQ_IDLE:
          if (trigger)
          begin
            mode_r <= wr_mode;
            step_r <= 2'h0;
            seq_r  <= SEQ_REQ;
          end
        SEQ_REQ:  seq_r <= SEQ_WAIT;
        SEQ_WAIT:
          if (conv_done)
          begin
            if (step_r == last_step)
              seq_r <= SEQ_COMMIT;
            else
            begin
              step_r <= step_r + 2'h1;
              seq_r  <= SEQ_REQ;
            end
          end
        SEQ_COMMIT: seq_r <= SEQ_IDLE;
        default:    seq_r <= SEQ_IDLE;
      endcase
    end

  // Converter request outputs and divider gating
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      conv_req  <= '0;
      sampled_r <= 1'b0;
    end
    else
    begin
      conv_req.start      <= ~pd & (seq_r == SEQ_REQ);
      conv_req.chan       <= chan;
      conv_req.bias_high  <= (mode_r == MODE_TDIFF) & (step_r == 2'h1);  // RULE_16
      if (seq_r == SEQ_REQ)
        sampled_r <= 1'b0;
      else if (conv_sample_end)
        sampled_r <= 1'b1;
      conv_req.divider_en <= ((seq_r == SEQ_REQ) | (seq_r == SEQ_WAIT)) & ~sampled_r
                             & ~conv_sample_end & ((chan == CH_BATTERY_INPUT_ONE) | (chan == CH_BATTERY_INPUT_TWO));  // RULE_15
    end

  // Holding slots; results published together at commit
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
    begin
      tmp_r <= '{default: '0};
      res_r <= '{default: ZERO_WORD};
    end
    else if (!pd)
    begin
      if (seq_r == SEQ_WAIT && conv_done)
        tmp_r[step_r] <= conv_result;
      if (seq_r == SEQ_COMMIT)
      begin
        case (mode_r)
          MODE_SCAN:
          begin
            res_r[0] <= {4'h0, tmp_r[0]};               // RULE_14 RULE_20
            res_r[1] <= {4'h0, tmp_r[1]};
            res_r[2] <= {4'h0, tmp_r[2]};
          end
          MODE_TDIFF:
          begin
            res_r[3] <= {4'h0, tmp_r[0]};               // RULE_16 RULE_20
            res_r[4] <= {4'h0, tmp_r[1]};
          end
          default: res_r[3] <= {4'h0, tmp_r[0]};        // RULE_17
        endcase
      end
    end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_write_after_cmd: assert property (@(posedge ref_clk) disable iff (!rst_n) wr_stb |-> cmd_seen_r) // RULE_01
    else $error("write without command");
  a_past_end_ones: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_07
    (word_done && load_rd && load_ptr >= PAGE_DEPTH) |=> tx_sh_r == ALL_ONES)
    else $error("past page end not all ones");
  a_resv_page_ones: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_22
    (word_done && load_rd && load_pg > PAGE_AUDIO) |=> tx_sh_r == ALL_ONES)
    else $error("reserved page not all ones");
  a_resv_no_write: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_22
    wr_stb |-> (cmd_r.page == PAGE_AUXCTL || cmd_r.page == PAGE_AUDIO))
    else $error("write reached reserved page");
  a_ptr_advance: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_06
    (data_done && !ss_fall && !ss_s && ptr_r < PAGE_DEPTH) |=> ptr_r == $past(ptr_r) + 7'h01)
    else $error("pointer did not advance");
  a_cmd_decode: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_04
    (cmd_done && !ss_s) |=> (ptr_r == {1'b0, $past(rx_word[10:5])} && cmd_r.rd == $past(rx_word[15])))
    else $error("command decode wrong");
  a_miso_first_edge: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_18
    $changed(miso_r) |-> $past(sclk_rise))
    else $error("data out moved off first edge");
  a_divider_bat: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_15
    conv_req.divider_en |-> (conv_req.chan == CH_BATTERY_INPUT_ONE || conv_req.chan == CH_BATTERY_INPUT_TWO))
    else $error("divider on outside battery sampling");
  a_pd_freeze: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_12
    (pd && $past(pd)) |-> ($stable(seq_r) && $stable(step_r)))
    else $error("sequencer moved in power down");
  a_high_bias: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_16
    (seq_r == SEQ_REQ && !pd && mode_r == MODE_TDIFF && step_r == 2'h1) |=> conv_req.start && conv_req.bias_high)
    else $error("second temperature step not at high bias");
  a_result_format: assert property (@(posedge ref_clk) disable iff (!rst_n) // RULE_20
    res_r[0][15:12] == 4'h0 && res_r[3][15:12] == 4'h0 && res_r[4][15:12] == 4'h0)
    else $error("result upper bits not zero");
endmodule : scd_decoder

// ### verif/scd_host_model.sv
/*
  Host model for the serial command decoder: drives select, clock and words.
  Assumes one caller of frame() at a time, clocked from ref_clk.
*/
`timescale 1ns/10ps
module scd_host_model
(
  // Clock
  input  wire logic ref_clk,
  // Serial pins
  output logic      sclk_pin,
  output logic      ss_n_pin,
  output logic      serial_data_in_pin,
  input  wire logic serial_data_out_pin
);
  logic [15:0] tx_w [8];
  logic [15:0] rx_w [8];

  // Idle bus: clock low, select high
  initial
  begin
    sclk_pin = 1'b0;
    ss_n_pin = 1'b1;
    serial_data_in_pin = 1'b0;
  end

  // One select period; 16 ref_clk per half bit gives a 160 ns clock
  task automatic frame(input int n);
    @(posedge ref_clk) ss_n_pin <= 1'b0;
    repeat (16) @(posedge ref_clk);
    for (int w = 0; w < n; w++)
    begin
      for (int b = 15; b >= 0; b--)
      begin
        sclk_pin <= 1'b1;
        serial_data_in_pin <= tx_w[w][b];
        repeat (16) @(posedge ref_clk);
        sclk_pin <= 1'b0;
        rx_w[w][b] = serial_data_out_pin;
        repeat (16) @(posedge ref_clk);
      end
    end
    ss_n_pin <= 1'b1;
    // Released line flips so a stale bit is never taken for data
    serial_data_in_pin <= ~serial_data_in_pin;
    repeat (16) @(posedge ref_clk);
  endtask : frame
endmodule : scd_host_model

// ### verif/test_scd_decoder.sv
/*
  Self-checking bench for the serial command decoder with converter model.
  Assumes the host model drives the serial pins; the bench drives the rest.
*/
`timescale 1ns/10ps
module test_scd_decoder
  import scd_pkg::*;
;
  logic             ref_clk, rst_n, sclk_pin, ss_n_pin, serial_data_in_pin;
  logic             serial_data_out_pin, serial_data_out_oe;
  logic             powerdown_or_wordselect_pin, hw_powerdown_active, converter_word_select;
  scd_conv_s        conv_req;
  logic             conv_sample_end = 1'b0, conv_done = 1'b0;
  logic [RES_W-1:0] conv_result = '0;
  int               n_mismatch, checks_done, cyc, cv_cnt;
  scd_chan_e        cv_chan;
  logic             cv_bias;
  scd_chan_e        log_ch[$];
  logic             log_b[$];

  scd_decoder dut (.ref_clk(ref_clk), .rst_n(rst_n), .sclk_pin(sclk_pin), .ss_n_pin(ss_n_pin),
    .serial_data_in_pin(serial_data_in_pin), .serial_data_out_pin(serial_data_out_pin),
    .serial_data_out_oe(serial_data_out_oe), .powerdown_or_wordselect_pin(powerdown_or_wordselect_pin),
    .hw_powerdown_active(hw_powerdown_active), .converter_word_select(converter_word_select),
    .conv_req(conv_req), .conv_sample_end(conv_sample_end), .conv_done(conv_done),
    .conv_result(conv_result));
  scd_host_model host (.ref_clk(ref_clk), .sclk_pin(sclk_pin), .ss_n_pin(ss_n_pin),
    .serial_data_in_pin(serial_data_in_pin), .serial_data_out_pin(serial_data_out_pin));

  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("checks=%0d mismatches=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : tally_and_finish

  // Result pattern encodes channel and bias so swaps show up
  function automatic logic [11:0] res_of(input scd_chan_e c, input logic b);
    return {4'ha, c, b, 5'h11};
  endfunction : res_of

  // Converter model: fixed 10-cycle conversion, divider checked mid-sample and after
  always @(posedge ref_clk)
  begin
    conv_sample_end <= 1'b0;
    conv_done <= 1'b0;
    conv_result <= ~conv_result;
    if (cv_cnt != 0)
    begin
      cv_cnt <= cv_cnt - 1;
      if (cv_cnt == 7) chk(conv_req.divider_en, cv_chan inside {CH_BATTERY_INPUT_ONE, CH_BATTERY_INPUT_TWO});
      if (cv_cnt == 6) conv_sample_end <= 1'b1;
      if (cv_cnt == 2) chk(conv_req.divider_en, 1'b0);
      if (cv_cnt == 1)
      begin
        conv_done <= 1'b1;
        conv_result <= res_of(cv_chan, cv_bias);
      end
    end
    else if (rst_n && conv_req.start === 1'b1)
    begin
      cv_cnt <= 10;
      cv_chan <= conv_req.chan;
      cv_bias <= conv_req.bias_high;
      log_ch.push_back(conv_req.chan);
      log_b.push_back(conv_req.bias_high);
    end
  end

  // Hang guard: the tests need about 60k cycles
  always @(posedge ref_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      n_mismatch++;
      tally_and_finish();
    end
  end

  task automatic rd(input logic [3:0] pg, input logic [5:0] idx, input int n);
    host.tx_w[0] = {1'b1, pg, idx, 5'h00};
    for (int i = 1; i < 8; i++) host.tx_w[i] = 16'h0000;
    host.frame(n + 1);
  endtask : rd

  task automatic wr(input logic [3:0] pg, input logic [5:0] idx, input logic [15:0] d);
    host.tx_w[0] = {1'b0, pg, idx, 5'h00};
    host.tx_w[1] = d;
    host.frame(2);
  endtask : wr

  task automatic wait_log(input int n);
    for (int i = 0; i < 3000 && log_ch.size() < n; i++) @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
    chk(log_ch.size(), n);
  endtask : wait_log

  task automatic t_reset();
    // Channel select follows the idle sequencer once released, so only the strobes must rest at zero
    chk({serial_data_out_oe, hw_powerdown_active, converter_word_select}, 16'h0000);
    chk({conv_req.start, conv_req.bias_high, conv_req.divider_en}, 16'h0000);
    rd(PAGE_DATA, 6'h05, 6);
    for (int i = 1; i <= 6; i++) chk(host.rx_w[i], 16'h0000);
    wr(PAGE_AUDIO, 6'h01, 16'h1234);
    rd(PAGE_AUDIO, 6'h01, 1);
    chk(host.rx_w[1], 16'h1234);
    @(posedge ref_clk) rst_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    // Every output sits at its reset level while reset is held
    chk({serial_data_out_pin, serial_data_out_oe, hw_powerdown_active, converter_word_select}, 16'h0000);
    chk(conv_req, 16'h0000);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    rd(PAGE_AUDIO, 6'h01, 1);
    chk(host.rx_w[1], 16'h0000);
    $display("t_reset done");
  endtask : t_reset

  task automatic t_autoinc();
    host.tx_w[0] = {1'b0, PAGE_AUDIO, 6'h1e, 5'h00};
    host.tx_w[1] = 16'ha5a1;
    host.tx_w[2] = 16'h8040;
    host.tx_w[3] = 16'h0ddd;
    host.frame(4);
    rd(PAGE_AUDIO, 6'h1d, 5);
    chk(host.rx_w[1], 16'h0000);
    chk(host.rx_w[2], 16'ha5a1);
    chk(host.rx_w[3], 16'h8040);
    chk(host.rx_w[4], ALL_ONES);
    chk(host.rx_w[5], ALL_ONES);
    rd(PAGE_AUDIO, 6'h25, 1);
    chk(host.rx_w[1], ALL_ONES);
    $display("t_autoinc done");
  endtask : t_autoinc

  task automatic t_reserved();
    for (int p = 3; p < 16; p++)
    begin
      wr(4'(p), 6'h00, 16'h7777);
      rd(4'(p), 6'h00, 1);
      chk(host.rx_w[1], ALL_ONES);
    end
    wr(PAGE_DATA, 6'h05, 16'h0abc);
    rd(PAGE_AUDIO, 6'h00, 1);
    chk(host.rx_w[1], 16'h0000);
    rd(PAGE_DATA, 6'h05, 1);
    chk(host.rx_w[1], 16'h0000);
    $display("t_reserved done");
  endtask : t_reserved

  task automatic t_meas();
    wr(PAGE_AUXCTL, 6'h00, 16'h0001);
    wait_log(3);
    chk({log_ch[0], log_ch[1], log_ch[2]}, {10'h0, CH_BATTERY_INPUT_ONE, CH_BATTERY_INPUT_TWO, CH_AUX});
    rd(PAGE_DATA, 6'h05, 3);
    chk(host.rx_w[1], {4'h0, res_of(CH_BATTERY_INPUT_ONE, 1'b0)});
    chk(host.rx_w[2], {4'h0, res_of(CH_BATTERY_INPUT_TWO, 1'b0)});
    chk(host.rx_w[3], {4'h0, res_of(CH_AUX, 1'b0)});
    rd(PAGE_AUXCTL, 6'h00, 1);
    chk(host.rx_w[1], 16'h0001);
    log_ch.delete();
    log_b.delete();
    wr(PAGE_AUXCTL, 6'h00, 16'h0002);
    wait_log(1);
    chk({log_ch[0], log_b[0]}, {CH_TEMP, 1'b0});
    rd(PAGE_DATA, 6'h09, 2);
    chk(host.rx_w[1], {4'h0, res_of(CH_TEMP, 1'b0)});
    chk(host.rx_w[2], 16'h0000);
    log_ch.delete();
    log_b.delete();
    wr(PAGE_AUXCTL, 6'h00, 16'h0003);
    wait_log(2);
    chk({log_ch[0], log_b[0], log_ch[1], log_b[1]}, {CH_TEMP, 1'b0, CH_TEMP, 1'b1});
    rd(PAGE_DATA, 6'h09, 2);
    chk(host.rx_w[1], {4'h0, res_of(CH_TEMP, 1'b0)});
    chk(host.rx_w[2], {4'h0, res_of(CH_TEMP, 1'b1)});
    $display("t_meas done");
  endtask : t_meas

  task automatic t_pin();
    log_ch.delete();
    log_b.delete();
    @(posedge ref_clk) powerdown_or_wordselect_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk({hw_powerdown_active, converter_word_select}, 16'h0002);
    wr(PAGE_AUXCTL, 6'h00, 16'h0001);
    wr(PAGE_AUDIO, 6'h03, 16'h0c0c);
    repeat (200) @(posedge ref_clk);
    chk(log_ch.size(), 16'h0000);
    @(posedge ref_clk) powerdown_or_wordselect_pin <= 1'b1;
    repeat (100) @(posedge ref_clk);
    rd(PAGE_AUDIO, 6'h03, 1);
    chk(host.rx_w[1], 16'h0c0c);
    wr(PAGE_AUDIO, 6'h06, 16'h0001);
    repeat (6) @(posedge ref_clk);
    chk({hw_powerdown_active, converter_word_select}, 16'h0001);
    @(posedge ref_clk) powerdown_or_wordselect_pin <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk({hw_powerdown_active, converter_word_select}, 16'h0000);
    $display("t_pin done");
  endtask : t_pin

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    powerdown_or_wordselect_pin = 1'b1;
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_autoinc();
    t_reserved();
    t_meas();
    t_pin();
    tally_and_finish();
  end
endmodule : test_scd_decoder
